// file: hdl/rcw_pkg.sv
package rcw_pkg;
	// Register offsets on the serial register port
	localparam logic [3:0] ADDR_SEC = 4'h0;
	localparam logic [3:0] ADDR_MIN = 4'h1;
	localparam logic [3:0] ADDR_HOUR = 4'h2;
	localparam logic [3:0] ADDR_DOW = 4'h3;
	localparam logic [3:0] ADDR_DATE = 4'h4;
	localparam logic [3:0] ADDR_MON = 4'h5;
	localparam logic [3:0] ADDR_YEAR = 4'h6;
	localparam logic [3:0] ADDR_WK_LO = 4'hA;
	localparam logic [3:0] ADDR_WK_MID = 4'hB;
	localparam logic [3:0] ADDR_WK_HI = 4'hC;
	localparam logic [3:0] ADDR_FEAT = 4'hD;
	localparam logic [3:0] ADDR_FLAGS = 4'hE;
	localparam logic [3:0] ADDR_CTRL = 4'hF;
	// Field positions
	localparam int BIT_WAKE_EN = 4;
	localparam int BIT_WAKE_FLAG = 4;
	localparam int BIT_WAKE_IRQ_EN = 4;
	localparam int BIT_HALT = 0;
	localparam int BIT_SRC_HI = 1;
	localparam int BIT_SRC_LO = 0;
	// Writable bit masks of the counters and control bytes
	localparam logic [7:0] MASK_SEC = 8'h7F;
	localparam logic [7:0] MASK_MIN = 8'h7F;
	localparam logic [7:0] MASK_HOUR = 8'h3F;
	localparam logic [7:0] MASK_DOW = 8'h7F;
	localparam logic [7:0] MASK_DATE = 8'h3F;
	localparam logic [7:0] MASK_MON = 8'h1F;
	localparam logic [7:0] MASK_CTRL = 8'h3D;
	// BCD limits
	localparam logic [7:0] BCD_00 = 8'h00;
	localparam logic [7:0] BCD_01 = 8'h01;
	localparam logic [7:0] BCD_02 = 8'h02;
	localparam logic [7:0] BCD_12 = 8'h12;
	localparam logic [7:0] BCD_23 = 8'h23;
	localparam logic [7:0] BCD_59 = 8'h59;
	localparam logic [7:0] BCD_60 = 8'h60;
	localparam logic [7:0] BCD_99 = 8'h99;
	localparam logic [7:0] DOW_FIRST = 8'h01;
	// Oscillator divider: 32768 Hz in, stage taps
	localparam int DIV_W = 15;
	localparam int DIV_SUBSEC_LSB = 6;
	localparam logic [2:0] DIV_4096_END = 3'h7;
	localparam logic [8:0] DIV_64_END = 9'h1FF;
	localparam logic [14:0] DIV_1_END = 15'h7FFF;
	// Wake source select codes
	localparam logic [1:0] SRC_4096HZ = 2'h0;
	localparam logic [1:0] SRC_64HZ = 2'h1;
	localparam logic [1:0] SRC_1HZ = 2'h2;
	localparam logic [1:0] SRC_1MIN = 2'h3;
	// Interrupt release times
	localparam int CLK_PERIOD_NS = 50;
	localparam int IRQ_RELEASE_FAST_NS = 122000;
	localparam int IRQ_RELEASE_SLOW_NS = 7813000;
	localparam int IRQ_FAST_CYC = IRQ_RELEASE_FAST_NS / CLK_PERIOD_NS;
	localparam int IRQ_SLOW_CYC = IRQ_RELEASE_SLOW_NS / CLK_PERIOD_NS;
	localparam int IRQ_CNT_W = 18;
	localparam int WAKE_W = 24;
	// Timekeeping freeze states
	typedef enum logic [0:0] {TK_RUN, TK_HOLD} rcw_tk_state_t;
endpackage

// file: hdl/rcw_wake_if.sv
`timescale 1ns/1ps
interface rcw_wake_if #(parameter int W = 24);
	logic tick; // Selected source tick, one cycle
	logic enable; // Wake timer enable level
	logic [W-1:0] preset; // Reload value
	logic [W-1:0] count; // Live down-count
	logic event_p; // Period elapsed, one cycle
	modport ctl (output tick, output enable, output preset, input count, input event_p);
	modport tmr (input tick, input enable, input preset, output count, output event_p);
endinterface

// file: hdl/rcw_wake_timer.sv
`timescale 1ns/1ps
module rcw_wake_timer (
	input wire logic clk_sys,
	input wire logic arst_n,
	rcw_wake_if.tmr wk
);
	import rcw_pkg::*;

	logic en_q; // Enable seen last cycle, for the start edge
	logic [WAKE_W-1:0] cnt; // Down-counter
	logic fire; // Period ends on this tick

	// A count of one at a tick closes the period; zero wraps for a full 2^24 period
	assign fire = wk.enable && en_q && wk.tick && (cnt == WAKE_W'(1));
	assign wk.count = cnt;

	// Enable edge tracker
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			en_q <= 1'b0;
		end else begin
			en_q <= wk.enable;
		end
	end

	// Countdown with reload
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			cnt <= '0;
		end else if (wk.enable && !en_q) begin
			cnt <= wk.preset;
		end else if (fire) begin
			cnt <= wk.preset;
		end else if (wk.enable && wk.tick) begin
			cnt <= cnt - WAKE_W'(1);
		end
	end

	// Event strobe is registered so it lines up with the reload
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			wk.event_p <= 1'b0;
		end else begin
			wk.event_p <= fire;
		end
	end
endmodule

// file: hdl/rcw_rtc_core.sv
`timescale 1ns/1ps
// What this block does
// - Freeze time during access, apply carry after
// - Counting starts when halt goes one-to-zero
// - Seconds, minutes BCD modulo 60 with carry
// - Seconds write clears sub-second divider stages
// - Hours BCD 24-hour, incremented by minute carry
// - Seconds accept 60, then go to 00
// - Weekday one-hot rotates left on hour carry
// - Weekday gives no carry, independent of calendar
// - Date modulo 28..31 by month; month modulo 12
// - Year two-digit BCD 00 to 99
// - Years divisible by four are leap years
// - Wake timer raises periodic events, can pause
// - Interrupt auto-releases after 122us or 7.813ms
// - Wake preset 24 bits over three bytes
// - Counter reads: preset when idle, live when running
// - Two-bit select picks 4096, 64, 1, 1/60 Hz
// - Unused preset bytes serve as storage
// - Wake flag sticky, write-zero clears, keeps pin
// - Enable rising edge restarts from preset
// - Irq enable gates pin; clearing releases it
module rcw_rtc_core #(
	parameter int IRQ_SLOW_CYCLES = rcw_pkg::IRQ_SLOW_CYC
) (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic osc_32k,
	input wire logic link_clk,
	input wire logic link_frame,
	input wire logic link_wr,
	input wire logic link_rd,
	input wire logic [3:0] link_addr,
	input wire logic [7:0] link_wdata,
	output logic link_busy,
	output logic [7:0] link_rdata,
	output logic link_rd_valid,
	input wire logic irq_n_in,
	output logic irq_n_out,
	output logic irq_n_oe
);
	import rcw_pkg::*;

	// BCD increment of a two-digit byte
	function automatic logic [7:0] bcd_inc(input logic [7:0] v);
		if (v[3:0] >= 4'h9) begin
			bcd_inc = {v[7:4] + 4'h1, 4'h0};
		end else begin
			bcd_inc = {v[7:4], v[3:0] + 4'h1};
		end
	endfunction

	// Year divisible by four: 10t+u mod 4 equals 2t+u mod 4
	function automatic logic is_leap(input logic [7:0] yr);
		logic [1:0] m;
		m = {yr[4], 1'b0} + yr[1:0];
		is_leap = (m == 2'h0);
	endfunction

	// Last date of a month in BCD
	function automatic logic [7:0] last_date(input logic [7:0] mo, input logic leap);
		case (mo)
			8'h02: last_date = leap ? 8'h29 : 8'h28;
			8'h04, 8'h06, 8'h09, 8'h11: last_date = 8'h30;
			default: last_date = 8'h31;
		endcase
	endfunction

	// ---------------- Link domain ----------------
	logic req_tog; // Toggles once per request
	logic req_we; // Held request kind
	logic [3:0] req_addr; // Held address
	logic [7:0] req_wdata; // Held write data
	logic [2:0] ack_sync_l; // Ack toggle into link domain
	logic ack_seen_l; // Last ack toggle consumed
	logic ack_edge_l; // Ack arrived, second and third agree
	logic [7:0] rd_byte; // Read answer held in system domain
	logic ack_tog; // Answer toggle back to link, driven in the system domain

	assign ack_edge_l = (ack_sync_l[1] == ack_sync_l[2]) && (ack_sync_l[2] != ack_seen_l);
	// Busy until the answer returns; the serial engine waits on it
	assign link_busy = (req_tog != ack_seen_l);

	// Request launch; fields stay put until the ack is back
	always_ff @(posedge link_clk or negedge arst_n) begin
		if (!arst_n) begin
			req_tog <= 1'b0;
			req_we <= 1'b0;
			req_addr <= 4'h0;
			req_wdata <= 8'h00;
		end else if (!link_busy && (link_wr || link_rd)) begin
			req_tog <= ~req_tog;
			req_we <= link_wr;
			req_addr <= link_addr;
			req_wdata <= link_wdata;
		end
	end

	// Ack return and read data capture
	always_ff @(posedge link_clk or negedge arst_n) begin
		if (!arst_n) begin
			ack_sync_l <= 3'h0;
			ack_seen_l <= 1'b0;
			link_rdata <= 8'h00;
			link_rd_valid <= 1'b0;
		end else begin
			ack_sync_l <= {ack_sync_l[1:0], ack_tog};
			link_rd_valid <= ack_edge_l && !req_we;
			if (ack_edge_l) begin
				ack_seen_l <= ack_sync_l[2];
				link_rdata <= rd_byte; // Stable: written in the same cycle the ack toggled
			end
		end
	end

	// ---------------- System domain: inputs ----------------
	logic [2:0] req_sync; // Request toggle
	logic [2:0] frame_sync; // Frame level
	logic [2:0] osc_sync; // Oscillator pin
	logic frame_lvl; // Debounced frame level
	logic osc_lvl; // Debounced oscillator level
	logic op_go; // Take the held request now
	logic osc_tick; // One 32768 Hz step

	// Three-stage synchronisers; only stages two and three are looked at
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			req_sync <= 3'h0;
			frame_sync <= 3'h0;
			osc_sync <= 3'h0;
			frame_lvl <= 1'b0;
			osc_lvl <= 1'b0;
		end else begin
			req_sync <= {req_sync[1:0], req_tog};
			frame_sync <= {frame_sync[1:0], link_frame};
			osc_sync <= {osc_sync[1:0], osc_32k};
			if (frame_sync[1] == frame_sync[2]) begin
				frame_lvl <= frame_sync[2];
			end
			if (osc_sync[1] == osc_sync[2]) begin
				osc_lvl <= osc_sync[2];
			end
		end
	end

	assign op_go = (req_sync[1] == req_sync[2]) && (req_sync[2] != ack_tog);
	assign osc_tick = (osc_sync[1] == osc_sync[2]) && osc_sync[2] && !osc_lvl;

	// ---------------- Registers ----------------
	logic [7:0] sec, min, hour, dow, date, mon, year; // Time and calendar
	logic [23:0] preset; // Wake preset, three bytes
	logic [7:0] feat; // Feature select byte
	logic [7:0] ctrl; // Irq enable and halt byte
	logic wake_flag; // Sticky wake event
	logic wr_go; // Register write this cycle
	logic halt; // Timekeeping halted
	logic wake_enable; // Wake timer enable
	logic wake_irq_en; // Wake interrupt enable
	logic [1:0] wake_src; // Wake source select

	assign wr_go = op_go && req_we;
	assign halt = ctrl[BIT_HALT];
	assign wake_enable = feat[BIT_WAKE_EN];
	assign wake_irq_en = ctrl[BIT_WAKE_IRQ_EN];
	assign wake_src = {feat[BIT_SRC_HI], feat[BIT_SRC_LO]};

	// ---------------- Oscillator divider ----------------
	logic [DIV_W-1:0] div; // 32768 Hz chain
	logic sec_tick; // Raw one-second step

	assign sec_tick = osc_tick && (div == DIV_1_END) && !halt;

	// Divider; sub-second stages held at zero while halted so release restarts a full second
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			div <= '0;
		end else begin
			if (osc_tick) begin
				div <= div + DIV_W'(1);
			end
			if (halt) begin
				div[DIV_W-1:DIV_SUBSEC_LSB] <= '0;
			end
			if (wr_go && (req_addr == ADDR_SEC)) begin
				div[DIV_W-1:DIV_SUBSEC_LSB] <= '0;
			end
		end
	end

	// ---------------- Freeze during access ----------------
	rcw_tk_state_t tk_state; // Run or hold
	logic pending; // Second deferred while held
	logic step; // Second applied to the counters

	// Hold while the frame is open or a request is still in flight
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			tk_state <= TK_RUN;
		end else begin
			case (tk_state)
				TK_RUN: if (frame_lvl) tk_state <= TK_HOLD;
				TK_HOLD: if (!frame_lvl && !op_go) tk_state <= TK_RUN;
				default: tk_state <= TK_RUN;
			endcase
		end
	end

	assign step = (tk_state == TK_RUN) && (sec_tick || pending);

	// One deferred second is kept; access frames are far shorter than a second
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			pending <= 1'b0;
		end else if (wr_go && (req_addr == ADDR_SEC)) begin
			pending <= 1'b0; // Fresh seconds value restarts the second
		end else if (sec_tick && (tk_state == TK_HOLD)) begin
			pending <= 1'b1;
		end else if (step) begin
			pending <= 1'b0;
		end
	end

	// ---------------- Time and calendar counting ----------------
	logic c_sec, c_min, c_hour, c_date, c_mon; // Carries of the chain

	assign c_sec = step && ((sec == BCD_59) || (sec >= BCD_60));
	assign c_min = c_sec && (min == BCD_59);
	assign c_hour = c_min && (hour == BCD_23);
	assign c_date = c_hour && (date >= last_date(mon, is_leap(year)));
	assign c_mon = c_date && (mon >= BCD_12);

	// Clock counters; a write to a register wins over its own count step
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			sec <= BCD_00;
			min <= BCD_00;
			hour <= BCD_00;
			dow <= DOW_FIRST;
		end else begin
			if (c_sec) begin
				sec <= BCD_00;
			end else if (step) begin
				sec <= bcd_inc(sec);
			end
			if (c_min) begin
				min <= BCD_00;
			end else if (c_sec) begin
				min <= bcd_inc(min);
			end
			if (c_hour) begin
				hour <= BCD_00;
			end else if (c_min) begin
				hour <= bcd_inc(hour);
			end
			if (c_hour) begin
				dow <= {1'b0, dow[5:0], dow[6]};
			end
			if (wr_go) begin
				case (req_addr)
					ADDR_SEC: sec <= req_wdata & MASK_SEC;
					ADDR_MIN: min <= req_wdata & MASK_MIN;
					ADDR_HOUR: hour <= req_wdata & MASK_HOUR;
					ADDR_DOW: dow <= req_wdata & MASK_DOW;
					default: ;
				endcase
			end
		end
	end

	// Calendar counters; the weekday is not part of this chain
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			date <= BCD_01;
			mon <= BCD_01;
			year <= BCD_00;
		end else begin
			if (c_date) begin
				date <= BCD_01;
			end else if (c_hour) begin
				date <= bcd_inc(date);
			end
			if (c_mon) begin
				mon <= BCD_01;
			end else if (c_date) begin
				mon <= bcd_inc(mon);
			end
			if (c_mon) begin
				year <= (year == BCD_99) ? BCD_00 : bcd_inc(year);
			end
			if (wr_go) begin
				case (req_addr)
					ADDR_DATE: date <= req_wdata & MASK_DATE;
					ADDR_MON: mon <= req_wdata & MASK_MON;
					ADDR_YEAR: year <= req_wdata;
					default: ;
				endcase
			end
		end
	end

	// ---------------- Wake timer ----------------
	rcw_wake_if #(.W(WAKE_W)) wk_if ();
	logic src_tick; // Selected countdown tick

	// Halt stops the 64 Hz, 1 Hz and minute sources; 4096 Hz keeps running
	always_comb begin
		case (wake_src)
			SRC_4096HZ: src_tick = osc_tick && (div[2:0] == DIV_4096_END);
			SRC_64HZ: src_tick = osc_tick && (div[8:0] == DIV_64_END) && !halt;
			SRC_1HZ: src_tick = step;
			default: src_tick = c_min;
		endcase
	end

	assign wk_if.tick = src_tick;
	assign wk_if.enable = wake_enable;
	assign wk_if.preset = preset;

	rcw_wake_timer u_wake (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.wk(wk_if.tmr)
	);

	// Preset bytes double as plain storage while the timer is unused
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			preset <= '0;
			feat <= 8'h00;
			ctrl <= 8'h00;
		end else if (wr_go) begin
			case (req_addr)
				ADDR_WK_LO: preset[7:0] <= req_wdata;
				ADDR_WK_MID: preset[15:8] <= req_wdata;
				ADDR_WK_HI: preset[23:16] <= req_wdata;
				ADDR_FEAT: feat <= req_wdata;
				ADDR_CTRL: ctrl <= req_wdata & MASK_CTRL;
				default: ;
			endcase
		end
	end

	// Sticky flag: an event in the clearing cycle still sets it
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			wake_flag <= 1'b0;
		end else if (wk_if.event_p) begin
			wake_flag <= 1'b1;
		end else if (wr_go && (req_addr == ADDR_FLAGS) && !req_wdata[BIT_WAKE_FLAG]) begin
			wake_flag <= 1'b0;
		end
	end

	// ---------------- Interrupt pin ----------------
	logic irq_act; // Pin pulled low
	logic [IRQ_CNT_W-1:0] irq_cnt; // Cycles left before auto release

	// Flag clearing and enable clearing leave this alone; only the irq enable releases early
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			irq_act <= 1'b0;
			irq_cnt <= '0;
		end else if (!wake_irq_en) begin
			irq_act <= 1'b0;
			irq_cnt <= '0;
		end else if (wk_if.event_p) begin
			irq_act <= 1'b1;
			if (wake_src == SRC_4096HZ) begin
				irq_cnt <= IRQ_CNT_W'(IRQ_FAST_CYC - 1);
			end else begin
				irq_cnt <= IRQ_CNT_W'(IRQ_SLOW_CYCLES - 1);
			end
		end else if (irq_act) begin
			if (irq_cnt == '0) begin
				irq_act <= 1'b0;
			end else begin
				irq_cnt <= irq_cnt - IRQ_CNT_W'(1);
			end
		end
	end

	// Open drain: only ever drives low
	assign irq_n_out = 1'b0;
	assign irq_n_oe = irq_act;

	// ---------------- Register read and answer ----------------
	logic [7:0] rd_mux; // Addressed byte
	logic [23:0] wk_view; // Preset or live count

	assign wk_view = wake_enable ? wk_if.count : preset;

	// Unmapped offsets read as zero; reading the pin level is not offered
	always_comb begin
		case (req_addr)
			ADDR_SEC: rd_mux = sec;
			ADDR_MIN: rd_mux = min;
			ADDR_HOUR: rd_mux = hour;
			ADDR_DOW: rd_mux = dow;
			ADDR_DATE: rd_mux = date;
			ADDR_MON: rd_mux = mon;
			ADDR_YEAR: rd_mux = year;
			ADDR_WK_LO: rd_mux = wk_view[7:0];
			ADDR_WK_MID: rd_mux = wk_view[15:8];
			ADDR_WK_HI: rd_mux = wk_view[23:16];
			ADDR_FEAT: rd_mux = feat;
			ADDR_FLAGS: rd_mux = {3'h0, wake_flag, 4'h0};
			ADDR_CTRL: rd_mux = ctrl;
			default: rd_mux = 8'h00;
		endcase
	end

	// Answer byte is captured in the same cycle the ack toggles; the ack still crosses the synchroniser, so the link sees it settled
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			rd_byte <= 8'h00;
			ack_tog <= 1'b0;
		end else if (op_go) begin
			rd_byte <= req_we ? rd_byte : rd_mux;
			ack_tog <= req_sync[2];
		end
	end
endmodule

// file: sim/rcw_rtc_core_chk.sv
`timescale 1ns/1ps
module rcw_rtc_core_chk
	import rcw_pkg::*;
#(
	parameter int IRQ_SLOW_CYCLES = IRQ_SLOW_CYC
) (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic link_clk,
	input wire logic link_wr,
	input wire logic link_rd,
	input wire logic [3:0] link_addr,
	input wire logic [7:0] link_wdata,
	input wire logic link_busy,
	input wire logic [7:0] link_rdata,
	input wire logic link_rd_valid,
	input wire logic irq_n_out,
	input wire logic irq_n_oe
);
	logic src_fast; // Source select is 4096 Hz
	logic irq_en; // Interrupt enable last written
	logic last_rd; // Request in flight is a read
	int oe_cnt; // Cycles the pin has been held low
	// Settings seen on taken writes; crossing skew is small beside the bounds
	always_ff @(posedge link_clk or negedge arst_n) begin
		if (!arst_n) begin
			src_fast <= 1'b1;
			irq_en <= 1'b0;
			last_rd <= 1'b0;
		end else if ((link_wr || link_rd) && !link_busy) begin
			last_rd <= !link_wr;
			if (link_wr && link_addr == ADDR_FEAT)
				src_fast <= (link_wdata[1:0] == SRC_4096HZ);
			if (link_wr && link_addr == ADDR_CTRL)
				irq_en <= link_wdata[BIT_WAKE_IRQ_EN];
		end
	end
	// Length of the current low pulse
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			oe_cnt <= 0;
		else
			oe_cnt <= irq_n_oe ? oe_cnt + 1 : 0;
	end
	property p_pin_low;
		@(posedge clk_sys) disable iff (!arst_n) irq_n_oe |-> !irq_n_out;
	endproperty
	a_pin_low: assert property (p_pin_low) else $error("pin not low");
	property p_irq_max;
		@(posedge clk_sys) disable iff (!arst_n)
		oe_cnt <= (src_fast ? IRQ_FAST_CYC : IRQ_SLOW_CYCLES);
	endproperty
	a_irq_max: assert property (p_irq_max) else $error("pin held too long");
	property p_irq_cause;
		@(posedge clk_sys) disable iff (!arst_n) $rose(irq_n_oe) |-> irq_en;
	endproperty
	a_irq_cause: assert property (p_irq_cause) else $error("pin low while disabled");
	property p_busy_cause;
		@(posedge link_clk) disable iff (!arst_n) $rose(link_busy) |-> $past(link_wr || link_rd);
	endproperty
	a_busy_cause: assert property (p_busy_cause) else $error("busy without request");
	property p_busy_bound;
		@(posedge link_clk) disable iff (!arst_n) $rose(link_busy) |-> ##[1:40] !link_busy;
	endproperty
	a_busy_bound: assert property (p_busy_bound) else $error("no answer");
	property p_valid_fall;
		@(posedge link_clk) disable iff (!arst_n)
		link_rd_valid |-> !link_busy && $past(link_busy);
	endproperty
	a_valid_fall: assert property (p_valid_fall) else $error("valid off answer");
	property p_valid_pulse;
		@(posedge link_clk) disable iff (!arst_n) link_rd_valid |=> !link_rd_valid;
	endproperty
	a_valid_pulse: assert property (p_valid_pulse) else $error("valid too long");
	property p_valid_kind;
		@(posedge link_clk) disable iff (!arst_n) $fell(link_busy) |-> link_rd_valid == last_rd;
	endproperty
	a_valid_kind: assert property (p_valid_kind) else $error("valid for wrong kind");
	property p_rdata_hold;
		@(posedge link_clk) disable iff (!arst_n) !link_rd_valid |-> $stable(link_rdata);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
endmodule
bind rcw_rtc_core rcw_rtc_core_chk #(.IRQ_SLOW_CYCLES(IRQ_SLOW_CYCLES)) u_rcw_rtc_core_chk (
	.clk_sys(clk_sys),
	.arst_n(arst_n),
	.link_clk(link_clk),
	.link_wr(link_wr),
	.link_rd(link_rd),
	.link_addr(link_addr),
	.link_wdata(link_wdata),
	.link_busy(link_busy),
	.link_rdata(link_rdata),
	.link_rd_valid(link_rd_valid),
	.irq_n_out(irq_n_out),
	.irq_n_oe(irq_n_oe)
);

// file: sim/rcw_host_model.sv
`timescale 1ns/1ps
module rcw_host_model (
	output logic link_clk,
	output logic link_frame,
	output logic link_wr,
	output logic link_rd,
	output logic [3:0] link_addr,
	output logic [7:0] link_wdata,
	input wire logic link_busy,
	input wire logic [7:0] link_rdata,
	input wire logic link_rd_valid
);
	initial begin
		link_clk = 1'b0;
		link_frame = 1'b0;
		link_wr = 1'b0;
		link_rd = 1'b0;
		link_addr = 4'h0;
		link_wdata = 8'h00;
	end
	// Serial clock runs only inside a frame and parks low between frames
	always begin
		#6;
		if (link_frame || link_clk)
			link_clk = ~link_clk;
	end
	// Open or close a communication
	task automatic frame(input logic on);
		if (on) begin
			link_frame = 1'b1;
			repeat (4) @(posedge link_clk);
		end else begin
			@(posedge link_clk);
			#1 link_frame = 1'b0;
		end
	endtask
	// One byte transfer; lines carry junk once the request is taken
	task automatic xfer(input logic wr, input logic [3:0] a, input logic [7:0] d,
		output logic [7:0] q);
		int n;
		@(posedge link_clk);
		#1;
		link_wr = wr;
		link_rd = !wr;
		link_addr = a;
		link_wdata = d;
		@(posedge link_clk);
		#1;
		link_wr = 1'b0;
		link_rd = 1'b0;
		link_addr = ~a;
		link_wdata = ~d;
		q = 8'h00;
		for (n = 0; n < 60; n++) begin
			@(posedge link_clk);
			#1;
			if (!link_busy) begin
				q = link_rdata;
				break;
			end
		end
		if (n == 60)
			tb_rcw_rtc_core.hang();
	endtask
endmodule

// file: sim/tb_rcw_rtc_core.sv
`timescale 1ns/1ps
module tb_rcw_rtc_core;
	import rcw_pkg::*;
	localparam int SLOW = 50; // Short slow release keeps the run small
	logic clk_sys = 1'b0;
	logic arst_n = 1'b0;
	logic osc_32k = 1'b0;
	int osc_cnt = 0;
	int errors = 0;
	int comparisons = 0;
	wire link_clk;
	wire link_frame;
	wire link_wr;
	wire link_rd;
	wire [3:0] link_addr;
	wire [7:0] link_wdata;
	logic link_busy;
	logic [7:0] link_rdata;
	logic link_rd_valid;
	logic irq_n_out;
	logic irq_n_oe;
	wire irq_pin;
	assign irq_pin = irq_n_oe ? irq_n_out : 1'b1; // Pull-up when released
	always #25 clk_sys = ~clk_sys;
	// Oscillator at a quarter of clk_sys; each level lasts two cycles so the
	// synchroniser's second and third stages can agree on it
	always @(negedge clk_sys) begin
		osc_cnt <= (osc_cnt == 3) ? 0 : osc_cnt + 1;
		osc_32k <= (osc_cnt < 2);
	end
	rcw_rtc_core #(.IRQ_SLOW_CYCLES(SLOW)) u_rcw_rtc_core (.clk_sys(clk_sys), .arst_n(arst_n),
		.osc_32k(osc_32k), .link_clk(link_clk), .link_frame(link_frame), .link_wr(link_wr),
		.link_rd(link_rd), .link_addr(link_addr), .link_wdata(link_wdata),
		.link_busy(link_busy), .link_rdata(link_rdata), .link_rd_valid(link_rd_valid),
		.irq_n_in(irq_pin), .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe));
	rcw_host_model u_rcw_host_model (.link_clk(link_clk), .link_frame(link_frame),
		.link_wr(link_wr), .link_rd(link_rd), .link_addr(link_addr), .link_wdata(link_wdata),
		.link_busy(link_busy), .link_rdata(link_rdata), .link_rd_valid(link_rd_valid));
	task automatic test_done();
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic hang();
		errors++;
		$display("[ERR] %0t wait ran out", $time);
		test_done();
	endtask
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_cnt(input int got, input int exp);
		comparisons++;
		if (got != exp) begin
			errors++;
			$display("[ERR] %0t count %0d expected %0d", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		logic [7:0] q;
		u_rcw_host_model.xfer(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		logic [7:0] q;
		u_rcw_host_model.xfer(1'b0, a, 8'h00, q);
		chk8(q, exp);
	endtask
	task automatic wait_irq(input int lim);
		int n;
		for (n = 0; n < lim; n++) begin
			@(negedge clk_sys);
			if (irq_n_oe === 1'b1)
				break;
		end
		if (n == lim)
			hang();
	endtask
	task automatic irq_len(output int len);
		len = 0;
		while (irq_n_oe === 1'b1 && len < 200000) begin
			@(negedge clk_sys);
			len++;
		end
	endtask
	// Fast source: live count, release time, sticky flag, enable gating
	task automatic sc_wake_fast();
		logic [7:0] p;
		logic [7:0] v;
		int n;
		u_rcw_host_model.frame(1'b1);
		wr(ADDR_FEAT, 8'h00);
		wr(ADDR_WK_LO, 8'h80);
		wr(ADDR_WK_MID, 8'h00);
		wr(ADDR_WK_HI, 8'h00);
		wr(ADDR_CTRL, 8'h10);
		rd(ADDR_WK_LO, 8'h80);
		wr(ADDR_FEAT, 8'h10);
		repeat (640) @(negedge clk_sys);
		u_rcw_host_model.xfer(1'b0, ADDR_WK_LO, 8'h00, p);
		for (n = 0; n < 8; n++) begin
			u_rcw_host_model.xfer(1'b0, ADDR_WK_LO, 8'h00, v);
			if (v === p)
				break;
			p = v;
		end
		chk8((v >= 8'h68 && v <= 8'h6E) ? 8'h01 : 8'h00, 8'h01);
		wait_irq(4500);
		irq_len(n);
		chk_cnt(n, IRQ_FAST_CYC);
		rd(ADDR_FLAGS, 8'h10);
		wr(ADDR_FLAGS, 8'h10);
		rd(ADDR_FLAGS, 8'h10);
		wr(ADDR_FLAGS, 8'h00);
		rd(ADDR_FLAGS, 8'h00);
		wait_irq(2500);
		wr(ADDR_FLAGS, 8'h00);
		chk8({7'h00, irq_n_oe}, 8'h01);
		wr(ADDR_CTRL, 8'h00);
		repeat (3) @(negedge clk_sys);
		chk8({7'h00, irq_n_oe}, 8'h00);
		wr(ADDR_FLAGS, 8'h00);
		n = 0;
		repeat (4200) begin
			@(negedge clk_sys);
			if (irq_n_oe !== 1'b0)
				n++;
		end
		chk_cnt(n, 0);
		rd(ADDR_FLAGS, 8'h10);
		u_rcw_host_model.frame(1'b0);
	endtask
	// Slow source release, every select code, storage bytes, unmapped place
	task automatic sc_wake_slow();
		int n;
		u_rcw_host_model.frame(1'b1);
		wr(ADDR_FEAT, 8'h00);
		wr(ADDR_WK_LO, 8'h01);
		wr(ADDR_CTRL, 8'h10);
		wr(ADDR_FEAT, 8'h11);
		wait_irq(3300);
		irq_len(n);
		chk_cnt(n, SLOW);
		wr(ADDR_FEAT, 8'h02);
		rd(ADDR_FEAT, 8'h02);
		wr(ADDR_FEAT, 8'h03);
		rd(ADDR_FEAT, 8'h03);
		wr(ADDR_CTRL, 8'h00);
		wr(ADDR_WK_MID, 8'h5A);
		rd(ADDR_WK_MID, 8'h5A);
		wr(ADDR_WK_LO, 8'hA5);
		rd(ADDR_WK_LO, 8'hA5);
		wr(4'h7, 8'hFF);
		rd(4'h7, 8'h00);
		u_rcw_host_model.frame(1'b0);
	endtask
	// Carry through seconds, minutes, hours, weekday and date held back by an open frame, applied when it closes
	task automatic sc_calendar();
		u_rcw_host_model.frame(1'b1);
		wr(ADDR_YEAR, 8'h00);
		wr(ADDR_MON, 8'h02);
		wr(ADDR_DATE, 8'h28);
		wr(ADDR_HOUR, 8'h23);
		wr(ADDR_MIN, 8'h59);
		wr(ADDR_DOW, 8'h40);
		wr(ADDR_SEC, 8'h59);
		repeat (131200) @(negedge clk_sys);
		rd(ADDR_SEC, 8'h59);
		u_rcw_host_model.frame(1'b0);
		repeat (20) @(negedge clk_sys);
		u_rcw_host_model.frame(1'b1);
		rd(ADDR_SEC, 8'h00);
		rd(ADDR_MIN, 8'h00);
		rd(ADDR_HOUR, 8'h00);
		rd(ADDR_DOW, 8'h01);
		rd(ADDR_DATE, 8'h29);
		rd(ADDR_MON, 8'h02);
		rd(ADDR_YEAR, 8'h00);
		u_rcw_host_model.frame(1'b0);
	endtask
	initial begin
		u_rcw_host_model.frame(1'b1);
		repeat (3) @(negedge clk_sys);
		arst_n <= 1'b1;
		u_rcw_host_model.frame(1'b0);
		repeat (3) @(negedge clk_sys);
		sc_wake_fast();
		sc_wake_slow();
		sc_calendar();
		test_done();
	end
endmodule
